// >>> shared/asad_defines.vh
// constants for the alternate-space access decoder
// assumes: included by bare name from design and bench files
`ifndef ASAD_DEFINES_VH
`define ASAD_DEFINES_VH

// ***************************
// space identifiers
// ***************************
`define ASAD_SP_REAL      8'h14
`define ASAD_SP_REAL_IO   8'h15
`define ASAD_SP_REAL_LE   8'h1C
`define ASAD_SP_REAL_IOLE 8'h1D
`define ASAD_SP_PST_LO    8'hC0
`define ASAD_SP_PST_HI    8'hC5
`define ASAD_SP_PSTL_LO   8'hC8
`define ASAD_SP_PSTL_HI   8'hCD
`define ASAD_SP_FL_LO     8'hD0
`define ASAD_SP_FL_HI     8'hD3
`define ASAD_SP_FLL_LO    8'hD8
`define ASAD_SP_FLL_HI    8'hDB
`define ASAD_SP_BLK_LO    8'hE0
`define ASAD_SP_BLK_HI    8'hE1

// ***************************
// space classes
// ***************************
`define ASAD_CL_NORMAL  3'h0
`define ASAD_CL_UNASGN  3'h1
`define ASAD_CL_PST     3'h2
`define ASAD_CL_FL      3'h3
`define ASAD_CL_BLK     3'h4
`define ASAD_CL_REAL    3'h5
`define ASAD_CL_REALIO  3'h6

// ***************************
// fault context codes
// ***************************
`define ASAD_CTX_PRI    2'h0
`define ASAD_CTX_SEC    2'h1
`define ASAD_CTX_UNASGN 2'h3

// ***************************
// page attribute bit positions
// ***************************
`define ASAD_ATTR_W   5
`define ASAD_AT_WR    0
`define ASAD_AT_PRIV  1
`define ASAD_AT_SIDE  2
`define ASAD_AT_CV    3
`define ASAD_AT_CP    4

// ***************************
// register map (byte addresses)
// ***************************
`define ASAD_REG_CTRL     8'h00
`define ASAD_REG_WATCH_LO 8'h04
`define ASAD_REG_WATCH_HI 8'h08
`define ASAD_REG_STATUS   8'h0C
`define ASAD_CTRL_WRD     0
`define ASAD_CTRL_WWR     1
`define ASAD_CTRL_RST     32'h0000_0000

`endif

// >>> verilog/asad_classify.v
// space identifier classifier for the decoder
// assumes: pure decode, no clock; the caller registers the results
`timescale 1ns/1ns
`default_nettype none
`include "asad_defines.vh"

module asad_classify (
  // space identifier in
  input  wire [7:0] asi,
  // class out
  output reg  [2:0] cls,
  output wire       secondary
);

  // inclusive range test, used for every table band
  function in_rng;
    input [7:0] v;
    input [7:0] lo;
    input [7:0] hi;
    begin
      in_rng = (v >= lo) && (v <= hi);
    end
  endfunction

  // unassigned bands; anything not listed is left to other blocks
  wire unasgn = in_rng(asi, 8'h00, 8'h03) | in_rng(asi, 8'h05, 8'h0B) |
                in_rng(asi, 8'h0D, 8'h0F) | in_rng(asi, 8'h12, 8'h13) |
                in_rng(asi, 8'h1A, 8'h1B) | in_rng(asi, 8'h28, 8'h29) |
                (asi == 8'h2D) | (asi == 8'h30) | (asi == 8'h34) |
                (asi == 8'h38) | (asi == 8'h3C) | (asi == 8'h41) |
                in_rng(asi, 8'h48, 8'h4A) | (asi == 8'h4E) | (asi == 8'h53) |
                in_rng(asi, 8'h61, 8'h65) | in_rng(asi, 8'h68, 8'h71) |
                in_rng(asi, 8'h75, 8'h7F) | in_rng(asi, 8'h84, 8'h87) |
                in_rng(asi, 8'h8C, 8'hBF) | in_rng(asi, 8'hC6, 8'hC7) |
                in_rng(asi, 8'hCE, 8'hCF) | in_rng(asi, 8'hD4, 8'hD7) |
                in_rng(asi, 8'hDC, 8'hDF) | in_rng(asi, 8'hE4, 8'hE9) |
                in_rng(asi, 8'hEC, 8'hEF) | in_rng(asi, 8'hF2, 8'hF7) |
                in_rng(asi, 8'hFA, 8'hFF);

  // odd identifiers in the faulting bands are secondary context
  assign secondary = asi[0];

  // class decode
  always @* begin
    cls = `ASAD_CL_NORMAL;
    if (unasgn) begin
      cls = `ASAD_CL_UNASGN;
    end else if (in_rng(asi, `ASAD_SP_PST_LO, `ASAD_SP_PST_HI) |
                 in_rng(asi, `ASAD_SP_PSTL_LO, `ASAD_SP_PSTL_HI)) begin
      cls = `ASAD_CL_PST;
    end else if (in_rng(asi, `ASAD_SP_FL_LO, `ASAD_SP_FL_HI) |
                 in_rng(asi, `ASAD_SP_FLL_LO, `ASAD_SP_FLL_HI)) begin
      cls = `ASAD_CL_FL;
    end else if (in_rng(asi, `ASAD_SP_BLK_LO, `ASAD_SP_BLK_HI)) begin
      cls = `ASAD_CL_BLK;
    end else if (asi == `ASAD_SP_REAL || asi == `ASAD_SP_REAL_LE) begin
      cls = `ASAD_CL_REAL;
    end else if (asi == `ASAD_SP_REAL_IO || asi == `ASAD_SP_REAL_IOLE) begin
      cls = `ASAD_CL_REALIO;
    end
  end

endmodule // asad_classify
`default_nettype wire

// >>> verilog/asad_decoder.v
// alternate-space access decoder: classifies, checks and forms addresses
// assumes: a combinational translation lookup answers in the request cycle;
// registers reached over APB, one cycle of wait state per transfer
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "asad_defines.vh"

module asad_decoder #(
  parameter PA_W = 40,
  parameter AW   = 8
) (
  // clock and reset
  input  wire              clk,
  input  wire              rst,
  // request from the load/store pipeline
  input  wire              req_valid,
  input  wire [7:0]        req_asi,
  input  wire [63:0]       req_rs1,
  input  wire [63:0]       req_rs2,
  input  wire              req_load,
  input  wire              req_store,
  input  wire              req_dbl_float,
  input  wire              req_atomic,
  // translation lookup result and mode
  input  wire              mmu_bypass,
  input  wire              tlb_hit,
  input  wire [PA_W-1:0]   tlb_pa,
  input  wire [`ASAD_ATTR_W-1:0] tlb_attr,
  input  wire              tlb_trap,
  // answer to the pipeline
  output reg               rsp_valid_r,
  output reg               rsp_dae_r,
  output reg  [1:0]        rsp_ctx_r,
  output reg               rsp_misalign_r,
  output reg               rsp_dst_misalign_r,
  output reg               rsp_dld_misalign_r,
  output reg               rsp_watch_r,
  output reg               rsp_use_tlb_r,
  output reg  [63:0]       rsp_ra_r,
  output reg  [PA_W-1:0]   rsp_pa_r,
  output reg  [`ASAD_ATTR_W-1:0] rsp_attr_r,
  output reg               rsp_l2_only_r,
  output reg               rsp_sync_fault_status_reg_load_r,
  output reg  [`ASAD_ATTR_W-1:0] rsp_sync_fault_status_reg_attr_r,
  // apb slave
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [AW-1:0]     paddr,
  input  wire [31:0]       pwdata,
  output reg  [31:0]       prdata_r,
  output reg               pready_r,
  output reg               pslverr_r
);

  // ***************************
  // classification
  // ***************************
  // the classifier is pure decode; its answer is used in the request cycle
  wire [2:0] cls;
  wire       sec;

  asad_classify u_cls (
    .asi       (req_asi),
    .cls       (cls),
    .secondary (sec)
  );

  // effective address is a plain sum; rs2 is never a mask
  wire [63:0] va = req_rs1 + req_rs2;

  // ***************************
  // software registers
  // ***************************
  // control, watch address and fault history; only the watch gates requests
  reg [31:0] ctrl_r;
  reg [63:0] watch_r;
  reg [1:0]  last_ctx_r;
  reg        last_dae_r;
  reg [15:0] fault_cnt_r;

  // ***************************
  // checks
  // ***************************
  wire is_pst  = (cls == `ASAD_CL_PST);
  wire is_fl   = (cls == `ASAD_CL_FL);
  wire is_blk  = (cls == `ASAD_CL_BLK);
  wire is_un   = (cls == `ASAD_CL_UNASGN);
  wire is_rl   = (cls == `ASAD_CL_REAL);
  wire is_rio  = (cls == `ASAD_CL_REALIO);
  wire special = is_pst | is_fl | is_blk;

  // double-float direction for the alignment checks; the watchpoint and l2-only path use load and store directly
  wire dst = req_dbl_float & req_store;
  wire dld = req_dbl_float & req_load;

  // alignment is judged on the summed address, never on rs1 alone;
  // a word fault hides the doubleword one so only one trap is raised
  wire word_bad = |va[1:0];
  wire dbl_bad  = ~word_bad & va[2];

  // watchpoint covers one doubleword, enabled per direction
  // no byte mask: any access inside the watched doubleword matches
  wire watch_dir = (req_load  & ctrl_r[`ASAD_CTRL_WRD]) |
                   (req_store & ctrl_r[`ASAD_CTRL_WWR]);
  wire watch_hit = watch_dir & (va[63:3] == watch_r[63:3]);

  // which accesses get which alignment check
  wire chk_word = is_pst | ((is_fl | is_blk) & (dst | dld)) |
                  (is_fl & dld);
  wire chk_dst  = special & dst;
  wire chk_dld  = is_fl & dld;

  reg        t_mis;
  reg        t_dst;
  reg        t_dld;
  reg        t_wat;
  reg        t_dae;
  reg [1:0]  t_ctx;

  // trap selection; alignment first, then watchpoint, then the fault
  // the special spaces always fault in the end, so the precise traps must
  // be decided ahead of it or software would never see them
  always @* begin
    t_mis = 1'b0;
    t_dst = 1'b0;
    t_dld = 1'b0;
    t_wat = 1'b0;
    t_dae = 1'b0;
    t_ctx = `ASAD_CTX_PRI;
    if (chk_word & word_bad) begin
      t_mis = 1'b1;
    end else if (chk_dst & dbl_bad) begin
      t_dst = 1'b1;
    end else if (chk_dld & dbl_bad) begin
      t_dld = 1'b1;
    end else if (special & watch_hit) begin
      t_wat = 1'b1;
    end else if (special) begin
      t_dae = 1'b1;
      t_ctx = sec ? `ASAD_CTX_SEC : `ASAD_CTX_PRI;
    end else if (is_un) begin
      t_dae = 1'b1;
      t_ctx = `ASAD_CTX_UNASGN;
    end else if (is_rio & req_atomic) begin
      t_dae = 1'b1;
    end
  end

  // ***************************
  // real-space address forming
  // ***************************
  // bypass takes the address straight from the sum; translation leaves
  // the physical address and attributes to the lookup
  wire real_sp = is_rl | is_rio;
  wire byp     = real_sp & mmu_bypass;
  wire xlat    = real_sp & ~mmu_bypass;

  // forced attribute set, never taken from the lookup
  reg [`ASAD_ATTR_W-1:0] f_attr;

  // forced attributes on bypass; cacheable stays clear in both cases
  always @* begin
    f_attr = {`ASAD_ATTR_W{1'b0}};
    f_attr[`ASAD_AT_WR] = 1'b1;
    if (is_rio) begin
      f_attr[`ASAD_AT_SIDE] = 1'b1;
    end
  end

  // attributes handed to the pipeline
  wire [`ASAD_ATTR_W-1:0] attr_sel = byp ? f_attr : tlb_attr;
  // a lookup trap only counts for a real space taken through translation
  wire any_trap = t_mis | t_dst | t_dld | t_wat | t_dae | (xlat & tlb_trap);

  // ***************************
  // response stage
  // ***************************
  // one register stage; every answer stands for exactly one cycle and is
  // cleared by reset so the pipeline never sees a stale trap
  always @(posedge clk) begin
    if (rst) begin
      rsp_valid_r        <= 1'b0;
      rsp_dae_r          <= 1'b0;
      rsp_ctx_r          <= 2'h0;
      rsp_misalign_r     <= 1'b0;
      rsp_dst_misalign_r <= 1'b0;
      rsp_dld_misalign_r <= 1'b0;
      rsp_watch_r        <= 1'b0;
      rsp_use_tlb_r      <= 1'b0;
      rsp_ra_r           <= 64'h0;
      rsp_pa_r           <= {PA_W{1'b0}};
      rsp_attr_r         <= {`ASAD_ATTR_W{1'b0}};
      rsp_l2_only_r      <= 1'b0;
      rsp_sync_fault_status_reg_load_r    <= 1'b0;
      rsp_sync_fault_status_reg_attr_r    <= {`ASAD_ATTR_W{1'b0}};
    end else begin
      rsp_valid_r        <= req_valid;
      rsp_dae_r          <= req_valid & t_dae;
      rsp_ctx_r          <= t_ctx;
      rsp_misalign_r     <= req_valid & t_mis;
      rsp_dst_misalign_r <= req_valid & t_dst;
      rsp_dld_misalign_r <= req_valid & t_dld;
      rsp_watch_r        <= req_valid & t_wat;
      rsp_use_tlb_r      <= req_valid & ~byp;
      // the real address is the full sum, whatever the space
      rsp_ra_r           <= va;
      rsp_pa_r           <= byp ? va[PA_W-1:0] : tlb_pa;
      rsp_attr_r         <= attr_sel;
      // loads through a bypass never hit the first-level cache
      rsp_l2_only_r      <= req_valid & byp & req_load &
                            ~attr_sel[`ASAD_AT_CP];
      rsp_sync_fault_status_reg_load_r    <= req_valid & any_trap;
      // a miss gives all-zero attributes to the fault status
      rsp_sync_fault_status_reg_attr_r    <= (xlat & tlb_hit) ? tlb_attr :
                            {`ASAD_ATTR_W{1'b0}};
    end
  end

  // ***************************
  // apb slave
  // ***************************
  // a transfer is taken at setup and completes at the first access edge
  wire setup  = psel & ~penable;
  wire finish = psel & penable & pready_r;
  wire wr_en  = finish & pwrite & ~pslverr_r;

  // decode used only for the error answer; the read mux decodes paddr on its own
  // an unmapped offset answers with an error and changes nothing
  function mapped;
    input [AW-1:0] a;
    begin
      mapped = (a == `ASAD_REG_CTRL) | (a == `ASAD_REG_WATCH_LO) |
               (a == `ASAD_REG_WATCH_HI) | (a == `ASAD_REG_STATUS);
    end
  endfunction

  reg [31:0] rd_mux;

  // read mux; status shows the last fault seen
  // reading has no side effect, so a status poll never loses a fault
  always @* begin
    case (paddr)
      `ASAD_REG_CTRL:     rd_mux = ctrl_r;
      `ASAD_REG_WATCH_LO: rd_mux = watch_r[31:0];
      `ASAD_REG_WATCH_HI: rd_mux = watch_r[63:32];
      `ASAD_REG_STATUS:   rd_mux = {fault_cnt_r, 13'h0000,
                                    last_dae_r, last_ctx_r};
      default:            rd_mux = 32'h0000_0000;
    endcase
  end

  // one wait state: answer lands in the first access cycle
  always @(posedge clk) begin
    if (rst) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= setup;
      if (setup) begin
        pslverr_r <= ~mapped(paddr);
        prdata_r  <= pwrite ? 32'h0000_0000 : rd_mux;
      end else if (finish) begin
        pslverr_r <= 1'b0;
        prdata_r  <= 32'h0000_0000;
      end
    end
  end

  // writable registers
  // only the two enable bits of control are kept; the rest read as zero
  always @(posedge clk) begin
    if (rst) begin
      ctrl_r  <= `ASAD_CTRL_RST;
      watch_r <= 64'h0;
    end else if (wr_en) begin
      case (paddr)
        `ASAD_REG_CTRL:     ctrl_r <= {30'h0, pwdata[1:0]};
        `ASAD_REG_WATCH_LO: watch_r[31:0] <= pwdata;
        `ASAD_REG_WATCH_HI: watch_r[63:32] <= pwdata;
        default:            ctrl_r <= ctrl_r;
      endcase
    end
  end

  // fault history; a write to status clears it, a new fault wins
  // the count wraps at its width; software clears it before it matters
  always @(posedge clk) begin
    if (rst) begin
      last_ctx_r  <= 2'h0;
      last_dae_r  <= 1'b0;
      fault_cnt_r <= 16'h0000;
    end else if (req_valid & t_dae) begin
      last_ctx_r  <= t_ctx;
      last_dae_r  <= 1'b1;
      fault_cnt_r <= fault_cnt_r + 16'h0001;
    end else if (wr_en && paddr == `ASAD_REG_STATUS) begin
      last_ctx_r  <= 2'h0;
      last_dae_r  <= 1'b0;
      fault_cnt_r <= 16'h0000;
    end
  end

endmodule // asad_decoder
`default_nettype wire

// >>> dv/asad_tlb_model.sv
// translation lookup model for the alternate-space decoder
// assumes: answers combinationally in the request cycle, miss driven by the bench
`timescale 1ns/1ns
`default_nettype none

module asad_tlb_model (
  // lookup request
  input  wire logic        [63:0] va,
  input  wire logic               miss,
  // lookup answer
  output logic                    tlb_hit,
  output logic             [39:0] tlb_pa,
  output logic             [4:0]  tlb_attr,
  output logic                    tlb_trap
);
  // the real address goes in whole; the entry adds a fixed page offset
  assign tlb_hit  = !miss;
  assign tlb_pa   = va[39:0] + 40'h00_0010_0000;
  // on a miss the attribute lines carry junk, the inverted va[20:16], which is zero only when those bits are all ones
  assign tlb_attr = miss ? ~va[20:16] : va[20:16];
  assign tlb_trap = miss;
endmodule // asad_tlb_model
`default_nettype wire

// >>> dv/asad_decoder_properties.sv
// timing checks on the decoder's ports
// assumes: bound into asad_decoder, one clock, synchronous reset
`timescale 1ns/1ns
`default_nettype none
`include "asad_defines.vh"

module asad_properties #(
  parameter PA_W = 40
) (
  // clock, reset, request
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             req_valid,
  input  wire logic [7:0]       req_asi,
  input  wire logic [63:0]      req_rs1,
  input  wire logic [63:0]      req_rs2,
  input  wire logic             req_load,
  input  wire logic             req_dbl_float,
  input  wire logic             req_atomic,
  input  wire logic             mmu_bypass,
  input  wire logic             tlb_hit,
  input  wire logic [4:0]       tlb_attr,
  // answer
  input  wire logic             rsp_valid_r,
  input  wire logic             rsp_dae_r,
  input  wire logic [1:0]       rsp_ctx_r,
  input  wire logic             rsp_misalign_r,
  input  wire logic             rsp_dld_misalign_r,
  input  wire logic             rsp_watch_r,
  input  wire logic             rsp_use_tlb_r,
  input  wire logic [PA_W-1:0]  rsp_pa_r,
  input  wire logic [4:0]       rsp_attr_r,
  input  wire logic             rsp_l2_only_r,
  input  wire logic [4:0]       rsp_sync_fault_status_reg_attr_r,
  // apb
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pready_r
);
  // ***************************
  // request decode helpers
  // ***************************
  wire [63:0]     ea    = req_rs1 + req_rs2;
  wire [PA_W-1:0] ea_lo = ea[PA_W-1:0];
  wire            sec   = req_asi[0];
  wire            pst   = (req_asi >= `ASAD_SP_PST_LO && req_asi <= `ASAD_SP_PST_HI) ||
                          (req_asi >= `ASAD_SP_PSTL_LO && req_asi <= `ASAD_SP_PSTL_HI);
  wire            fl    = (req_asi >= `ASAD_SP_FL_LO && req_asi <= `ASAD_SP_FL_HI) ||
                          (req_asi >= `ASAD_SP_FLL_LO && req_asi <= `ASAD_SP_FLL_HI);
  wire            unas  = (req_asi[7:1] == 7'h63) || (req_asi >= 8'hDC && req_asi <= 8'hDF);
  wire            rl    = req_asi == `ASAD_SP_REAL || req_asi == `ASAD_SP_REAL_LE;
  wire            rio   = req_asi == `ASAD_SP_REAL_IO || req_asi == `ASAD_SP_REAL_IOLE;
  wire [4:0]      sfx   = tlb_hit ? tlb_attr : 5'h00;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_answer_follows: assert property (req_valid |=> rsp_valid_r)
    else $error("request got no answer");
  a_unasgn_fault: assert property (req_valid && unas |=> rsp_dae_r && rsp_ctx_r == 2'h3)
    else $error("unassigned space did not fault with code 3");
  a_fault_ctx: assert property (req_valid && pst && ea[2:0] == 3'h0 |=>
    rsp_watch_r || (rsp_dae_r && rsp_ctx_r == {1'b0, $past(sec)}))
    else $error("partial-store space fault code wrong");
  a_pst_word: assert property (req_valid && pst && ea[1:0] != 2'h0 |=> rsp_misalign_r && !rsp_dae_r)
    else $error("partial-store misalignment missed");
  a_fl_dword: assert property (req_valid && fl && req_dbl_float && req_load && ea[2:0] == 3'h4
    |=> rsp_dld_misalign_r && !rsp_dae_r)
    else $error("short-float double load misalignment missed");
  a_bypass_pa: assert property (req_valid && (rl || rio) && mmu_bypass |=>
    !rsp_use_tlb_r && rsp_pa_r == $past(ea_lo))
    else $error("bypass physical address wrong");
  a_real_attr: assert property (req_valid && rl && mmu_bypass |=> rsp_attr_r == 5'h01 && rsp_l2_only_r == $past(req_load))
    else $error("real bypass attributes wrong");
  a_realio_attr: assert property (req_valid && rio && mmu_bypass && !req_atomic |=> rsp_attr_r == 5'h05)
    else $error("real io bypass attributes wrong");
  a_atomic_io: assert property (req_valid && rio && req_atomic |=> rsp_dae_r)
    else $error("atomic to real io not refused");
  a_xlate_attr: assert property (req_valid && (rl || rio) && !mmu_bypass |=>
    rsp_use_tlb_r && rsp_sync_fault_status_reg_attr_r == $past(sfx))
    else $error("translated real fault attributes wrong");
  a_apb_ready: assert property (psel && !penable |=> pready_r ##1 !pready_r)
    else $error("apb wait state not one cycle");
endmodule // asad_properties

bind asad_decoder asad_properties #(.PA_W(PA_W)) asad_properties_inst (.*);
`default_nettype wire

// >>> dv/tb.sv
// self-checking bench for the alternate-space decoder
// assumes: design and lookup model compiled first, 10 MHz clock
`timescale 1ns/1ns
`default_nettype none
`include "asad_defines.vh"

module tb;
  typedef struct {
    logic [7:0]  asi;
    logic [63:0] a;
    logic [63:0] b;
    logic [4:0]  ctl;  // ld st dbl atomic bypass
    logic        miss;
    logic [3:0]  f;    // dae misalign dst dld
    logic [1:0]  ctx;
  } asad_row_t;

  logic clk = 0, rst = 1, req_valid = 0, req_load = 0, req_store = 0, req_dbl_float = 0;
  logic req_atomic = 0, mmu_bypass = 0, miss = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] req_asi = 0, paddr = 0;
  logic [63:0] req_rs1 = 0, req_rs2 = 0;
  logic [31:0] pwdata = 0, rd;
  logic err;
  wire [63:0] va = req_rs1 + req_rs2;
  wire tlb_hit, tlb_trap, rsp_valid_r, rsp_dae_r, rsp_misalign_r, rsp_dst_misalign_r, rsp_dld_misalign_r;
  wire rsp_watch_r, rsp_use_tlb_r, rsp_l2_only_r, rsp_sync_fault_status_reg_load_r, pready_r, pslverr_r;
  wire [39:0] tlb_pa, rsp_pa_r;
  wire [4:0] tlb_attr, rsp_attr_r, rsp_sync_fault_status_reg_attr_r;
  wire [1:0] rsp_ctx_r;
  wire [63:0] rsp_ra_r;
  wire [31:0] prdata_r;
  int bad_count = 0, samples_checked = 0, i;
  asad_row_t w;
  asad_row_t rows[] = '{
    '{8'hC6, 64'h100, 0, 5'h10, 0, 4'h8, 2'h3}, '{8'hDF, 64'h8, 0, 5'h08, 0, 4'h8, 2'h3},
    '{8'hC1, 0, 64'h8, 5'h08, 0, 4'h8, 2'h1}, '{8'hC8, 0, 64'h8, 5'h10, 0, 4'h8, 2'h0},
    '{8'hC0, 64'h6, 64'hFFFF_FFFF_FFFF_FFFC, 5'h08, 0, 4'h4, 0}, '{8'hD8, 64'h4, 0, 5'h14, 0, 4'h1, 0},
    '{8'hDB, 64'h4, 0, 5'h0C, 0, 4'h2, 0}, '{8'hD0, 64'h1, 0, 5'h0C, 0, 4'h4, 0},
    '{8'hD3, 64'h1, 0, 5'h10, 0, 4'h8, 2'h1}, '{8'hE0, 64'hC, 0, 5'h0C, 0, 4'h2, 0},
    '{8'hE1, 64'h8, 0, 5'h0C, 0, 4'h8, 2'h1}, '{8'h14, 64'hAB00_0080_1234_5670, 0, 5'h11, 0, 0, 0},
    '{8'h1C, 64'h12_3456_7000, 0, 5'h09, 0, 0, 0}, '{8'h15, 64'h80_0000_1000, 0, 5'h09, 0, 0, 0},
    '{8'h1D, 64'h80_0000_2000, 0, 5'h03, 0, 4'h8, 0}, '{8'h14, 64'h1_0000_001A_0000, 0, 5'h10, 0, 0, 0},
    '{8'h1C, 64'h15_0000, 0, 5'h10, 1, 0, 0}, '{8'h80, 64'h40, 0, 5'h10, 0, 0, 0}};

  asad_decoder asad_decoder_inst (.*);
  asad_tlb_model asad_tlb_model_inst (.va(va), .miss(miss), .tlb_hit(tlb_hit), .tlb_pa(tlb_pa),
                                      .tlb_attr(tlb_attr), .tlb_trap(tlb_trap));

  // ***************************
  // clock and shared tasks
  // ***************************
  always #50 clk = ~clk;

  task results;
    begin
      $display("checked %0d bad %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
        $display("No errors found");
      end else begin
        $display("Errors were found");
      end
      $finish;
    end
  endtask

  task chk(input string n, input logic [63:0] s, input logic [63:0] e);
    begin
      samples_checked++;
      if (s !== e) begin
        bad_count++;
        $display("BAD %s expected %h seen %h", n, e, s);
      end
    end
  endtask

  task drive(input asad_row_t r);
    begin
      req_valid <= 1;
      req_asi <= r.asi;
      req_rs1 <= r.a;
      req_rs2 <= r.b;
      {req_load, req_store, req_dbl_float, req_atomic, mmu_bypass} <= r.ctl;
      miss <= r.miss;
    end
  endtask

  // apb master: request held until pready is seen high at an edge
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    begin
      @(posedge clk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
      @(posedge clk);
      penable <= 1;
      n = 0;
      // ready, read data and error are all taken at the edge that ends the access
      do begin
        @(posedge clk);
        n++;
      end while (pready_r !== 1'b1 && n < 20);
      if (pready_r !== 1'b1) begin
        chk("apb wait", 0, 1);
        results;
      end
      rd = prdata_r;
      err = pslverr_r;
      {psel, penable} <= 2'b00;
    end
  endtask

  // answer to one row, seen in the cycle after it was taken
  task check_row(input asad_row_t r);
    logic [63:0] v;
    logic rl, byp, xl;
    begin
      v = r.a + r.b;
      rl = r.asi inside {8'h14, 8'h15, 8'h1C, 8'h1D};
      byp = rl && r.ctl[0];
      xl = rl && !r.ctl[0];
      chk("valid", rsp_valid_r, 1);
      chk("traps", {rsp_dae_r, rsp_misalign_r, rsp_dst_misalign_r, rsp_dld_misalign_r, rsp_watch_r}, {r.f, 1'b0});
      if (r.f[3]) chk("ctx", rsp_ctx_r, r.ctx);
      chk("ra", rsp_ra_r, v);
      chk("pa", rsp_pa_r, byp ? v[39:0] : v[39:0] + 40'h10_0000);
      chk("use_tlb", rsp_use_tlb_r, !byp);
      chk("l2_only", rsp_l2_only_r, byp && r.ctl[4]);
      if (rl && !r.f[3] && !r.miss) chk("attr", rsp_attr_r, byp ? (r.asi[0] ? 5'h05 : 5'h01) : v[20:16]);
      chk("sync_fault_status_reg_attr", rsp_sync_fault_status_reg_attr_r, (xl && !r.miss) ? v[20:16] : 5'h00);
      chk("sync_fault_status_reg_load", rsp_sync_fault_status_reg_load_r, |r.f || (xl && r.miss));
    end
  endtask

  // ***************************
  // main sequence
  // ***************************
  initial begin
    repeat (9) @(posedge clk);
    #1 chk("rst valid", {rsp_valid_r, pready_r, prdata_r}, 0);
    @(posedge clk);
    rst <= 0;
    // back-to-back rows, each answer checked while the next is taken
    for (i = 0; i <= rows.size(); i++) begin
      @(posedge clk);
      if (i < rows.size()) drive(rows[i]);
      else req_valid <= 0;
      #1 if (i > 0) check_row(rows[i-1]);
    end
    apb(0, `ASAD_REG_CTRL, 0);
    chk("ctrl reset", rd, `ASAD_CTRL_RST);
    apb(1, `ASAD_REG_CTRL, 32'h0000_0003);
    apb(1, `ASAD_REG_WATCH_LO, 32'h0000_1000);
    apb(1, `ASAD_REG_WATCH_HI, 0);
    apb(0, `ASAD_REG_CTRL, 0);
    chk("ctrl", rd, 32'h0000_0003);
    apb(1, `ASAD_REG_STATUS, 0);
    // watched store wins over the space's own fault
    w = '{8'hC0, 64'h1000, 0, 5'h08, 0, 0, 0};
    @(posedge clk);
    drive(w);
    @(posedge clk);
    req_valid <= 0;
    #1 chk("watch", {rsp_watch_r, rsp_dae_r}, 2'b10);
    // watched load to a block-commit space also wins over its fault
    w = '{8'hE1, 64'h1004, 0, 5'h10, 0, 0, 0};
    @(posedge clk);
    drive(w);
    @(posedge clk);
    req_valid <= 0;
    #1 chk("watch load", {rsp_watch_r, rsp_dae_r}, 2'b10);
    w = '{8'hC1, 64'h8, 0, 5'h10, 0, 0, 0};
    @(posedge clk);
    drive(w);
    @(posedge clk);
    req_valid <= 0;
    apb(0, `ASAD_REG_STATUS, 0);
    chk("status", rd, 32'h0001_0005);
    apb(0, 8'h10, 0);
    chk("unmapped", {err, rd}, 33'h1_0000_0000);
    // reset in mid-request clears the answer
    @(posedge clk);
    drive(w);
    rst <= 1;
    @(posedge clk);
    req_valid <= 0;
    #1 chk("mid reset", {rsp_valid_r, rsp_dae_r}, 0);
    @(posedge clk);
    rst <= 0;
    // answers stay quiet over the first edge after the release
    @(posedge clk);
    #1 chk("post reset", {rsp_valid_r, rsp_dae_r, pready_r}, 0);
    @(posedge clk);
    results;
  end
endmodule // tb
`default_nettype wire
